// ==== include/pfhp_pkg.sv ====
// Constants shared by the parallel FIFO host port
package pfhp_pkg;
  // ==========================================
  // Bus and storage
  localparam int PFHP_DATA_W = 8;
  localparam int PFHP_RX_DEPTH = 16;
  localparam int PFHP_TX_DEPTH = 16;

  // ==========================================
  // Timing, in ns and in clk_sys cycles
  localparam int PFHP_CLK_PERIOD_NS = 10;
  localparam int PFHP_STATUS_HOLD_NS = 80;
  localparam int PFHP_STATUS_UPDATE_MAX_NS = 25;
  localparam int PFHP_STATUS_HOLD_CYC = (PFHP_STATUS_HOLD_NS + PFHP_CLK_PERIOD_NS - 1) / PFHP_CLK_PERIOD_NS;
  localparam int PFHP_STATUS_UPDATE_MAX_CYC = PFHP_STATUS_UPDATE_MAX_NS / PFHP_CLK_PERIOD_NS;

  // ==========================================
  // Reset values
  localparam logic PFHP_STATUS_IDLE = 1'h1;
  localparam logic PFHP_STROBE_IDLE = 1'h1;
  localparam logic [PFHP_DATA_W-1:0] PFHP_DATA_RST = 8'h00;
endpackage : pfhp_pkg

// ==== design/pfhp_fifo.sv ====
// Show-ahead FIFO with registered head byte and flags
`timescale 1ns/1ns
module pfhp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  input wire logic pop,
  output logic [WIDTH-1:0] head,
  output logic has_data,
  output logic has_space
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("pfhp_fifo: DEPTH must be a power of two, at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [WIDTH-1:0] head;
    logic has_data;
    logic has_space;
  } pfhp_fifo_state_t;

  pfhp_fifo_state_t state;
  pfhp_fifo_state_t next_state;
  logic [WIDTH-1:0] mem [DEPTH];
  logic do_push;
  logic do_pop;

  // ==========================================
  // Pointer and flag logic
  always_comb begin
    do_push = push && state.has_space;
    do_pop = pop && state.has_data;
    next_state = state;
    if (do_push) begin
      next_state.wr_ptr = state.wr_ptr + AW'(1);
    end
    if (do_pop) begin
      next_state.rd_ptr = state.rd_ptr + AW'(1);
    end
    next_state.count = state.count + (AW+1)'(do_push) - (AW+1)'(do_pop);
    next_state.has_data = next_state.count != '0;
    next_state.has_space = next_state.count != (AW+1)'(DEPTH);
    // Bypass keeps the head right when a byte lands in the slot just exposed
    if (do_push && state.wr_ptr == next_state.rd_ptr) begin
      next_state.head = push_data;
    end else begin
      next_state.head = mem[next_state.rd_ptr];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= '{wr_ptr: '0, rd_ptr: '0, count: '0, head: '0, has_data: 1'b0, has_space: 1'b1};
    end else begin
      state <= next_state;
    end
  end

  // Storage needs no reset
  always_ff @(posedge clk_sys) begin
    if (do_push) begin
      mem[state.wr_ptr] <= push_data;
    end
  end

  assign head = state.head;
  assign has_data = state.has_data;
  assign has_space = state.has_space;
endmodule : pfhp_fifo

// ==== design/pfhp_holdoff.sv ====
// Retriggerable hold-off timer for a status output
`timescale 1ns/1ns
module pfhp_holdoff #(
  parameter int CYCLES = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic start,
  output logic busy
);
  localparam int CW = $clog2(CYCLES + 1);

  generate
    if (CYCLES < 1) begin : g_bad_cycles
      $error("pfhp_holdoff: CYCLES must be at least 1");
    end
  endgenerate

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic busy;
  } pfhp_hold_state_t;

  pfhp_hold_state_t state;
  pfhp_hold_state_t next_state;

  // ==========================================
  // Count down from start; busy for CYCLES cycles
  always_comb begin
    next_state = state;
    if (start) begin
      next_state.cnt = CW'(CYCLES);
      next_state.busy = 1'b1;
    end else if (state.cnt > CW'(1)) begin
      next_state.cnt = state.cnt - CW'(1);
    end else begin
      next_state.cnt = '0;
      next_state.busy = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= '{cnt: '0, busy: 1'b0};
    end else begin
      state <= next_state;
    end
  end

  assign busy = state.busy;
endmodule : pfhp_holdoff

// ==== design/pfhp_host_port.sv ====
// Parallel FIFO host port of one bridge channel
`timescale 1ns/1ns
// How it works
// - Receive status low only when byte waits
// - Drive receive head byte while read low
// - Read strobe rising edge pops next byte
// - Transmit status low when write allowed
// - Write strobe falling edge captures bus byte
// - Suspended wake strobe requests USB resume
// - Normal wake strobe flushes transmit buffer
// - Suspend indicator low normal, high suspended
// - Receive status updates within 25 ns
// - Receive status high 80 ns after read
// - Transmit status high 80 ns after write
// - Status pins released during reset
// - Idle pins pulled up, optionally down suspended
module pfhp_host_port
  import pfhp_pkg::*;
#(
  parameter int RX_DEPTH = PFHP_RX_DEPTH,
  parameter int TX_DEPTH = PFHP_TX_DEPTH,
  parameter int HOLD_CYCLES = PFHP_STATUS_HOLD_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  // Parallel bus side
  input wire logic [PFHP_DATA_W-1:0] fifo_data_bus_in,
  output logic [PFHP_DATA_W-1:0] fifo_data_bus_out,
  output logic fifo_data_bus_oe,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic send_now_wake_n,
  output logic rx_data_available_n,
  output logic tx_space_available_n,
  output logic status_oe,
  output logic suspend_power_indicator_n,
  output logic pins_pull_up,
  output logic pins_pull_down,
  // USB engine side
  input wire logic [PFHP_DATA_W-1:0] usb_rx_data,
  input wire logic usb_rx_valid,
  output logic usb_rx_ready,
  output logic [PFHP_DATA_W-1:0] usb_tx_data,
  output logic usb_tx_valid,
  input wire logic usb_tx_ready,
  input wire logic usb_suspended,
  input wire logic remote_wake_enable,
  input wire logic pull_low_in_suspend,
  output logic resume_request,
  output logic send_now
);

  // ==========================================
  // Elaboration checks
  generate
    if (HOLD_CYCLES < PFHP_STATUS_HOLD_CYC) begin : g_bad_hold
      $error("pfhp_host_port: HOLD_CYCLES shorter than the 80 ns status hold");
    end
    if (PFHP_STATUS_UPDATE_MAX_CYC < 1) begin : g_bad_clock
      $error("pfhp_host_port: clock too slow for the 25 ns status update");
    end
  endgenerate

  // ==========================================
  // State
  typedef struct packed {
    logic rd_n_q;
    logic wr_n_q;
    logic wake_n_q;
    logic rx_n;
    logic tx_n;
    logic [PFHP_DATA_W-1:0] data_out;
    logic data_oe;
    logic status_oe;
    logic susp_ind_n;
    logic pull_up;
    logic pull_down;
    logic resume_req;
    logic send_now;
  } pfhp_state_t;

  localparam pfhp_state_t PFHP_STATE_RST = '{
    rd_n_q: PFHP_STROBE_IDLE,
    wr_n_q: PFHP_STROBE_IDLE,
    wake_n_q: PFHP_STROBE_IDLE,
    rx_n: PFHP_STATUS_IDLE,
    tx_n: PFHP_STATUS_IDLE,
    data_out: PFHP_DATA_RST,
    data_oe: 1'b0,
    status_oe: 1'b0,
    susp_ind_n: 1'b0,
    pull_up: 1'b1,
    pull_down: 1'b0,
    resume_req: 1'b0,
    send_now: 1'b0
  };

  pfhp_state_t state;
  pfhp_state_t next_state;

  logic rd_rise;
  logic wr_fall;
  logic wake_fall;
  logic rx_pop;
  logic tx_push;
  logic [PFHP_DATA_W-1:0] rx_head;
  logic rx_has_data;
  logic rx_has_space;
  logic tx_has_data;
  logic tx_has_space;
  logic rx_hold_busy;
  logic tx_hold_busy;

  // ==========================================
  // Strobe edges
  always_comb begin
    rd_rise = !state.rd_n_q && read_strobe_n;
    wr_fall = state.wr_n_q && !write_strobe_n;
    wake_fall = state.wake_n_q && !send_now_wake_n;
    rx_pop = rd_rise && rx_has_data;
    // A write while transmit status is high is dropped
    tx_push = wr_fall && tx_has_space && !state.tx_n;
  end

  // ==========================================
  // Receive path: USB engine fills, host drains
  pfhp_fifo #(
    .WIDTH(PFHP_DATA_W),
    .DEPTH(RX_DEPTH)
  ) u_rx_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .push(usb_rx_valid),
    .push_data(usb_rx_data),
    .pop(rx_pop),
    .head(rx_head),
    .has_data(rx_has_data),
    .has_space(rx_has_space)
  );

  pfhp_holdoff #(
    .CYCLES(HOLD_CYCLES)
  ) u_rx_hold (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .start(rd_rise),
    .busy(rx_hold_busy)
  );

  // ==========================================
  // Transmit path: host fills, USB engine drains
  pfhp_fifo #(
    .WIDTH(PFHP_DATA_W),
    .DEPTH(TX_DEPTH)
  ) u_tx_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .push(tx_push),
    .push_data(fifo_data_bus_in),
    .pop(usb_tx_ready),
    .head(usb_tx_data),
    .has_data(tx_has_data),
    .has_space(tx_has_space)
  );

  pfhp_holdoff #(
    .CYCLES(HOLD_CYCLES)
  ) u_tx_hold (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .start(wr_fall),
    .busy(tx_hold_busy)
  );

  // ==========================================
  // Next state
  always_comb begin
    next_state = state;
    next_state.rd_n_q = read_strobe_n;
    next_state.wr_n_q = write_strobe_n;
    next_state.wake_n_q = send_now_wake_n;

    // Receive status goes high one clock after the read rising edge, transmit status one clock after the write falling edge
    next_state.rx_n = rd_rise || rx_hold_busy || !rx_has_data;
    next_state.tx_n = wr_fall || tx_hold_busy || !tx_has_space;

    // Head byte tracked every cycle; bus driven one clock after read low
    next_state.data_out = rx_head;
    next_state.data_oe = !read_strobe_n;

    // Released only while in reset
    next_state.status_oe = 1'b1;

    next_state.susp_ind_n = usb_suspended;
    next_state.pull_down = usb_suspended && pull_low_in_suspend;
    next_state.pull_up = !(usb_suspended && pull_low_in_suspend);

    // Wake strobe meaning depends on suspend state
    next_state.resume_req = wake_fall && usb_suspended && remote_wake_enable;
    next_state.send_now = wake_fall && !usb_suspended;
  end

  // ==========================================
  // State register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= PFHP_STATE_RST;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================
  // Outputs
  assign fifo_data_bus_out = state.data_out;
  assign fifo_data_bus_oe = state.data_oe;
  assign rx_data_available_n = state.rx_n;
  assign tx_space_available_n = state.tx_n;
  assign status_oe = state.status_oe;
  assign suspend_power_indicator_n = state.susp_ind_n;
  assign pins_pull_up = state.pull_up;
  assign pins_pull_down = state.pull_down;
  assign usb_rx_ready = rx_has_space;
  assign usb_tx_valid = tx_has_data;
  assign resume_request = state.resume_req;
  assign send_now = state.send_now;

endmodule : pfhp_host_port

// ==== tb/pfhp_host_port_assertions.sv ====
// Concurrent checks on the host port pins
`timescale 1ns/1ns
module pfhp_host_port_assertions #(
  parameter int HOLD_CYCLES = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic send_now_wake_n,
  input wire logic fifo_data_bus_oe,
  input wire logic rx_data_available_n,
  input wire logic tx_space_available_n,
  input wire logic status_oe,
  input wire logic suspend_power_indicator_n,
  input wire logic pins_pull_down,
  input wire logic usb_suspended,
  input wire logic remote_wake_enable,
  input wire logic pull_low_in_suspend,
  input wire logic resume_request,
  input wire logic send_now
);
  // ==========================================
  // Elaboration checks
  // Hold checks below count nine cycles, which a shorter hold could not meet
  generate
    if (HOLD_CYCLES < 8) begin : g_short_hold
      $error("pfhp_host_port_assertions: hold checks need HOLD_CYCLES of at least 8");
    end
  endgenerate

  // ==========================================
  // Properties
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_status_reset: assert property (disable iff (1'h0) !rst_n [*2] |-> !status_oe && rx_data_available_n)
    else $error("status pins driven in reset");
  a_rx_holdoff: assert property (read_strobe_n && !$past(read_strobe_n) |=> rx_data_available_n [*8] ##1 rx_data_available_n)
    else $error("receive status hold too short");
  a_tx_holdoff: assert property ($fell(write_strobe_n) && !tx_space_available_n |=> tx_space_available_n [*8] ##1 tx_space_available_n)
    else $error("transmit status hold too short");
  a_bus_drive: assert property (!read_strobe_n [*2] |-> fifo_data_bus_oe)
    else $error("bus not driven during read");
  a_bus_release: assert property (read_strobe_n [*2] |-> !fifo_data_bus_oe)
    else $error("bus driven outside read");
  a_resume_req: assert property ($fell(send_now_wake_n) && usb_suspended && remote_wake_enable |-> ##[1:2] resume_request)
    else $error("no resume request");
  a_send_now: assert property ($fell(send_now_wake_n) && !usb_suspended |-> ##[1:2] send_now)
    else $error("no send now pulse");
  // Skips the first edge after reset, where the indicator still shows its reset level
  a_suspend_ind: assert property ($past(rst_n) |-> suspend_power_indicator_n == $past(usb_suspended))
    else $error("suspend indicator wrong");
  a_pull_down: assert property ((usb_suspended && pull_low_in_suspend) [*3] |-> pins_pull_down)
    else $error("pull down not enabled");
endmodule : pfhp_host_port_assertions

bind pfhp_host_port pfhp_host_port_assertions #(.HOLD_CYCLES(HOLD_CYCLES)) u_chk (
  .clk_sys, .rst_n, .read_strobe_n, .write_strobe_n, .send_now_wake_n, .fifo_data_bus_oe, .rx_data_available_n,
  .tx_space_available_n, .status_oe, .suspend_power_indicator_n, .pins_pull_down, .usb_suspended,
  .remote_wake_enable, .pull_low_in_suspend, .resume_request, .send_now);

// ==== tb/pfhp_host_model.sv ====
// Host-side model of the parallel bus master
`timescale 1ns/1ns
module pfhp_host_model
  import pfhp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rx_data_available_n,
  input wire logic tx_space_available_n,
  input wire logic [PFHP_DATA_W-1:0] fifo_data_bus_out,
  input wire logic fifo_data_bus_oe,
  input wire logic pins_pull_down,
  output logic [PFHP_DATA_W-1:0] fifo_data_bus_in,
  output logic read_strobe_n,
  output logic write_strobe_n
);
  logic drv = 1'h0;
  logic [PFHP_DATA_W-1:0] d = 8'h00;
  initial read_strobe_n = 1'h1;
  initial write_strobe_n = 1'h1;
  // Released bus settles to the active weak pull
  assign fifo_data_bus_in = fifo_data_bus_oe ? fifo_data_bus_out : drv ? d : pins_pull_down ? 8'h00 : 8'hFF;
  // ==========================================
  // Bus cycles
  task automatic rd(output logic [PFHP_DATA_W-1:0] b);
    for (int i = 0; i < 100 && rx_data_available_n !== 1'h0; i++) @(posedge clk_sys);
    read_strobe_n <= 1'h0;
    repeat (6) @(posedge clk_sys);
    b = fifo_data_bus_in;
    read_strobe_n <= 1'h1;
    repeat (13) @(posedge clk_sys);
  endtask : rd
  task automatic wr(input logic [PFHP_DATA_W-1:0] b);
    for (int i = 0; i < 100 && tx_space_available_n !== 1'h0; i++) @(posedge clk_sys);
    d <= b;
    drv <= 1'h1;
    write_strobe_n <= 1'h0;
    repeat (6) @(posedge clk_sys);
    write_strobe_n <= 1'h1;
    @(posedge clk_sys);
    drv <= 1'h0;
    repeat (13) @(posedge clk_sys);
  endtask : wr
endmodule : pfhp_host_model

// ==== tb/tb_top.sv ====
// Self-checking bench for the parallel FIFO host port
`timescale 1ns/1ns
module tb_top;
  import pfhp_pkg::*;
  // ==========================================
  // Signals
  localparam int DEPTH = 4;
  logic clk_sys = 1'h0;
  logic rst_n = 1'h0;
  logic [7:0] fifo_data_bus_in, fifo_data_bus_out, usb_tx_data, b;
  logic [7:0] usb_rx_data = 8'h00;
  logic fifo_data_bus_oe, read_strobe_n, write_strobe_n, rx_data_available_n, tx_space_available_n, status_oe;
  logic suspend_power_indicator_n, pins_pull_up, pins_pull_down, usb_rx_ready, usb_tx_valid, resume_request, send_now;
  logic send_now_wake_n = 1'h1;
  logic usb_rx_valid = 1'h0;
  logic usb_tx_ready = 1'h0;
  logic usb_suspended = 1'h0;
  logic remote_wake_enable = 1'h0;
  logic pull_low_in_suspend = 1'h0;
  logic [1:0] r;
  logic [7:0] q[$];
  int n_errors = 0;
  int checked = 0;
  int seed = 42;
  always #5 clk_sys = ~clk_sys;
  pfhp_host_port #(.RX_DEPTH(DEPTH), .TX_DEPTH(DEPTH)) dut (
    .clk_sys, .rst_n, .fifo_data_bus_in, .fifo_data_bus_out, .fifo_data_bus_oe, .read_strobe_n, .write_strobe_n,
    .send_now_wake_n, .rx_data_available_n, .tx_space_available_n, .status_oe, .suspend_power_indicator_n,
    .pins_pull_up, .pins_pull_down, .usb_rx_data, .usb_rx_valid, .usb_rx_ready, .usb_tx_data, .usb_tx_valid,
    .usb_tx_ready, .usb_suspended, .remote_wake_enable, .pull_low_in_suspend, .resume_request, .send_now);
  pfhp_host_model host (
    .clk_sys, .rx_data_available_n, .tx_space_available_n, .fifo_data_bus_out, .fifo_data_bus_oe,
    .pins_pull_down, .fifo_data_bus_in, .read_strobe_n, .write_strobe_n);
  // ==========================================
  // Checking and closing
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done;
    if (n_errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done
  // Generous: the whole sequence needs well under a thousand cycles
  initial begin
    #100000;
    n_errors++;
    test_done();
  end
  // ==========================================
  // Scenarios
  initial begin
    repeat (2) @(posedge clk_sys);
    #1;
    check({5'h0, status_oe, rx_data_available_n, tx_space_available_n}, 8'h03);
    check({7'h0, pins_pull_up}, 8'h01);
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'h1;
    @(posedge clk_sys);
    @(negedge clk_sys);
    check({5'h0, status_oe, rx_data_available_n, tx_space_available_n}, 8'h06);
    @(posedge clk_sys);
    for (int i = 0; i <= DEPTH; i++) begin
      b = 8'($random(seed));
      if (i < DEPTH) q.push_back(b);
      usb_rx_data <= b;
      usb_rx_valid <= 1'h1;
      @(posedge clk_sys);
    end
    usb_rx_valid <= 1'h0;
    repeat (2) @(posedge clk_sys);
    #1;
    check({6'h0, usb_rx_ready, rx_data_available_n}, 8'h00);
    check(fifo_data_bus_in, 8'hFF);
    while (q.size() > 0) begin
      host.rd(b);
      check(b, q.pop_front());
    end
    repeat (20) @(posedge clk_sys);
    #1;
    check({7'h0, rx_data_available_n}, 8'h01);
    for (int i = 0; i < DEPTH; i++) begin
      b = 8'($random(seed));
      q.push_back(b);
      host.wr(b);
    end
    #1;
    check({7'h0, tx_space_available_n}, 8'h01);
    usb_tx_ready <= 1'h1;
    foreach (q[i]) begin
      @(negedge clk_sys);
      check(usb_tx_data, q[i]);
    end
    @(negedge clk_sys);
    check({7'h0, usb_tx_valid}, 8'h00);
    for (int i = 0; i < 3; i++) begin
      usb_suspended <= i > 0;
      remote_wake_enable <= i == 1;
      pull_low_in_suspend <= 1'h1;
      repeat (3) @(posedge clk_sys);
      #1;
      check({5'h0, suspend_power_indicator_n, pins_pull_down, pins_pull_up}, i > 0 ? 8'h06 : 8'h01);
      send_now_wake_n <= 1'h0;
      r = 2'h0;
      repeat (4) begin
        @(negedge clk_sys);
        r |= {resume_request, send_now};
      end
      send_now_wake_n <= 1'h1;
      check({6'h0, r}, i == 0 ? 8'h01 : i == 1 ? 8'h02 : 8'h00);
    end
    // ==========================================
    // Mid-run reset while suspended, with a byte waiting
    usb_rx_valid <= 1'h1;
    @(posedge clk_sys);
    usb_rx_valid <= 1'h0;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    check({7'h0, rx_data_available_n}, 8'h00);
    @(posedge clk_sys);
    rst_n <= 1'h0;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    check({2'h0, status_oe, rx_data_available_n, tx_space_available_n, suspend_power_indicator_n, pins_pull_down,
      pins_pull_up}, 8'h19);
    @(posedge clk_sys);
    rst_n <= 1'h1;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    check({2'h0, status_oe, rx_data_available_n, tx_space_available_n, suspend_power_indicator_n, pins_pull_down,
      pins_pull_up}, 8'h36);
    test_done();
  end
endmodule : tb_top
